// ### hdl/las_pkg.sv
// Package: register map, field layout and reset values of the alarm block
`default_nettype none
package las_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] FATAL_STATUS_ADDR   = 8'h20;
    localparam logic [7:0] WARNING_STATUS_ADDR = 8'h21;
    localparam logic [7:0] PWR_FATAL_TH_ADDR   = 8'h22;
    localparam logic [7:0] PWR_WARN_TH_ADDR    = 8'h23;
    localparam logic [7:0] FRQ_FATAL_TH_ADDR   = 8'h24;
    localparam logic [7:0] FRQ_WARN_TH_ADDR    = 8'h25;
    localparam logic [7:0] THM_FATAL_TH_ADDR   = 8'h26;
    localparam logic [7:0] THM_WARN_TH_ADDR    = 8'h27;
    localparam logic [7:0] SRQ_MASK_ADDR       = 8'h28;
    localparam logic [7:0] SEVERE_MASK_ADDR    = 8'h29;
    localparam logic [7:0] RESET_ADDR          = 8'h32;

    // ----------------------------------------------------------------
    // Status and reset register field positions
    // ----------------------------------------------------------------
    localparam int SRQ_FLAG_BIT    = 15;
    localparam int SEVERE_FLAG_BIT = 13;
    localparam int HW_DIS_BIT      = 12;
    localparam int EXEC_ERR_BIT    = 7;
    localparam int COMM_ERR_BIT    = 6;
    localparam int RESTART_BIT     = 5;
    localparam int LINK_RESET_BIT  = 4;
    localparam int MODULE_RST_BIT  = 0;
    localparam int SOFT_RST_BIT    = 1;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [15:0] SRQ_MASK_RST_BASE = 16'h1FBF;
    localparam logic [15:0] SEVERE_MASK_RST   = 16'h000F;
    localparam logic [7:0]  LATCH_RST         = 8'h30;
    localparam logic [15:0] TH_MAX_DEFAULT    = 16'h7FFF;
    localparam logic [15:0] TH_RST_DEFAULT    = 16'h0100;
    localparam logic [15:0] LINK_TIMEOUT_CYC  = 16'h2710;

    // Link selected by the two select pins
    typedef enum logic [1:0] {
        LAS_LINK_SPI,
        LAS_LINK_RS232,
        LAS_LINK_I2C,
        LAS_LINK_OTHER
    } las_link_e;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } las_req_s;

    // Monitored conditions: [3]=vendor [2]=freq [1]=thermal [0]=power
    typedef struct packed {
        logic [3:0]  severe_vendor_caution; // [3] severe vendor, [2:0] unused
        logic        caution_vendor;
        logic [15:0] pwr_dev;   // absolute, thousandths of dB
        logic [15:0] frq_dev;   // absolute, tenths of GHz
        logic [15:0] thm_dev;   // absolute, hundredths of deg C
    } las_mon_s;

endpackage

`default_nettype wire

// ### hdl/las_alarm.sv
// Alarm and status logic: thresholds, latched flags, request lines
// Operation
// - Thermal current bit 9 from thresholds
// - Power current bit 8 from thresholds
// - Latch execution errors in bit 7
// - Latch communication errors in bit 6
// - Restart sets bit 5, reset one
// - Reset register write requests module reset
// - Link reset clears input, sets bit 4
// - Incomplete packet timeout forces link reset
// - Bits 3:0 latch current bits 11:8
// - Writing one clears latched bit
// - Power thresholds in thousandths dB, absolute
// - Out-of-range threshold writes store maximum
// - Frequency thresholds in tenths GHz
// - Thermal thresholds in hundredths degree
// - Service request from masked status bits
// - Service mask reset depends on link
// - Mask rewrite or clear releases request
// - Severe line from masked status bits
// - RS232 immediate errors go to response
// - Hardware disable clears software output enable
// - Bits 15:8 current, writes ignored silently
// - Bits 15 and 13 mirror lines
`timescale 1ns/1ns
`default_nettype none

module las_alarm #(
    parameter logic [15:0] TH_MAX = las_pkg::TH_MAX_DEFAULT
) (
    input  wire logic            i_core_clk,
    input  wire logic            i_rstn,
    input  wire las_pkg::las_req_s i_req,
    input  wire logic            i_req_valid,
    input  wire las_pkg::las_mon_s i_mon,
    input  wire logic            i_exec_error_flag,
    input  wire logic            i_pending_exec_error,
    input  wire logic            i_comm_error,
    input  wire logic            i_fw_restart,
    input  wire logic            i_link_reset,
    input  wire logic            i_packet_busy,
    input  wire logic            i_hw_output_disable_pin_n,
    input  wire logic            i_link_select_pin_a,
    input  wire logic            i_link_select_pin_b,
    input  wire logic            i_immediate_error_latch_cfg,
    input  wire logic            i_sw_output_enable_set,
    output logic [15:0]          o_rdata,
    output logic                 o_service_request_line_n,
    output logic                 o_severe_fault_line_n,
    output logic                 o_module_reset_req,
    output logic                 o_soft_reset_req,
    output logic                 o_clear_input_buffers,
    output logic                 o_sw_output_enable,
    output logic [1:0]           o_link_sel
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  fatal_latch;
        logic [7:0]  warn_latch;
        logic [15:0] pwr_fatal_th;
        logic [15:0] pwr_warn_th;
        logic [15:0] frq_fatal_th;
        logic [15:0] frq_warn_th;
        logic [15:0] thm_fatal_th;
        logic [15:0] thm_warn_th;
        logic [15:0] srq_mask;
        logic [15:0] severe_mask;
        logic [15:0] timeout_cnt;
        logic        straps_taken;
        logic [1:0]  link_sel;
        logic        sw_enable;
        logic        dis_prev;
        logic        module_rst;
        logic        soft_rst;
        logic        clr_buf;
        logic        srq_n;
        logic        severe_n;
        logic [15:0] rdata;
    } las_state_s;

    las_state_s st_reg;
    las_state_s st_next;

    // Clamp a threshold write to the usable range
    function automatic logic [15:0] clamp_th(input logic [15:0] v);
        clamp_th = (v > TH_MAX) ? TH_MAX : v;
    endfunction

    // Current bits 11:8 for one threshold set
    function automatic logic [3:0] cur_bits(
        input logic        vendor,
        input logic [15:0] frq_th,
        input logic [15:0] thm_th,
        input logic [15:0] pwr_th,
        input las_pkg::las_mon_s m
    );
        cur_bits = {vendor,
                    m.frq_dev > frq_th,
                    m.thm_dev > thm_th,
                    m.pwr_dev > pwr_th};
    endfunction

    logic [3:0]  fatal_now;
    logic [3:0]  warn_now;
    logic        hw_disabled_flag;
    logic [15:0] fatal_status;
    logic [15:0] warning_status;
    logic        wr_hit;
    logic [7:0]  clr_f;
    logic [7:0]  clr_w;
    logic [7:0]  set_common;
    logic        link_rst_evt;

    // ----------------------------------------------------------------
    // Combinational next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        hw_disabled_flag = ~i_hw_output_disable_pin_n;
        fatal_now = cur_bits(i_mon.severe_vendor_caution[3],
                             st_reg.frq_fatal_th, st_reg.thm_fatal_th,
                             st_reg.pwr_fatal_th, i_mon);
        warn_now = cur_bits(i_mon.caution_vendor,
                            st_reg.frq_warn_th, st_reg.thm_warn_th,
                            st_reg.pwr_warn_th, i_mon);
        // Upper byte is current state only; writes never touch it
        fatal_status = {~st_reg.srq_n, 1'b0, ~st_reg.severe_n,
                        hw_disabled_flag, fatal_now,
                        st_reg.fatal_latch};
        warning_status = {~st_reg.srq_n, 1'b0, ~st_reg.severe_n,
                          hw_disabled_flag, warn_now,
                          st_reg.warn_latch};
        wr_hit = i_req_valid & i_req.wr;
        clr_f = 8'h00;
        clr_w = 8'h00;
        if (wr_hit && i_req.addr == las_pkg::FATAL_STATUS_ADDR) begin
            clr_f = i_req.wdata[7:0];
        end
        if (wr_hit && i_req.addr == las_pkg::WARNING_STATUS_ADDR) begin
            clr_w = i_req.wdata[7:0];
        end

        // Packet timeout counts only while a packet is open
        link_rst_evt = i_link_reset;
        if (i_packet_busy) begin
            if (st_reg.timeout_cnt == las_pkg::LINK_TIMEOUT_CYC) begin
                link_rst_evt = 1'b1;
                st_next.timeout_cnt = 16'h0000;
            end else begin
                st_next.timeout_cnt = st_reg.timeout_cnt + 16'h0001;
            end
        end else begin
            st_next.timeout_cnt = 16'h0000;
        end
        st_next.clr_buf = link_rst_evt;

        // Events shared by both status registers
        set_common = 8'h00;
        set_common[las_pkg::EXEC_ERR_BIT] = i_pending_exec_error |
            (i_exec_error_flag & i_immediate_error_latch_cfg);
        set_common[las_pkg::COMM_ERR_BIT] = i_comm_error &
            i_immediate_error_latch_cfg;
        set_common[las_pkg::RESTART_BIT] = i_fw_restart;
        set_common[las_pkg::LINK_RESET_BIT] = link_rst_evt;

        // Set wins over clear so no event is lost
        st_next.fatal_latch = (st_reg.fatal_latch & ~clr_f) | set_common
                              | {4'h0, fatal_now};
        st_next.warn_latch = (st_reg.warn_latch & ~clr_w) | set_common
                             | {4'h0, warn_now};

        // Register writes
        st_next.module_rst = 1'b0;
        st_next.soft_rst = 1'b0;
        if (wr_hit) begin
            case (i_req.addr)
                las_pkg::PWR_FATAL_TH_ADDR:
                    st_next.pwr_fatal_th = clamp_th(i_req.wdata);
                las_pkg::PWR_WARN_TH_ADDR:
                    st_next.pwr_warn_th = clamp_th(i_req.wdata);
                las_pkg::FRQ_FATAL_TH_ADDR:
                    st_next.frq_fatal_th = clamp_th(i_req.wdata);
                las_pkg::FRQ_WARN_TH_ADDR:
                    st_next.frq_warn_th = clamp_th(i_req.wdata);
                las_pkg::THM_FATAL_TH_ADDR:
                    st_next.thm_fatal_th = clamp_th(i_req.wdata);
                las_pkg::THM_WARN_TH_ADDR:
                    st_next.thm_warn_th = clamp_th(i_req.wdata);
                las_pkg::SRQ_MASK_ADDR:
                    st_next.srq_mask = i_req.wdata;
                las_pkg::SEVERE_MASK_ADDR:
                    st_next.severe_mask = i_req.wdata;
                las_pkg::RESET_ADDR: begin
                    st_next.module_rst =
                        i_req.wdata[las_pkg::MODULE_RST_BIT];
                    st_next.soft_rst = i_req.wdata[las_pkg::SOFT_RST_BIT];
                end
                default: ;
            endcase
        end

        // Link select straps caught once after reset release
        if (!st_reg.straps_taken) begin
            st_next.straps_taken = 1'b1;
            st_next.link_sel = {i_link_select_pin_b, i_link_select_pin_a};
            st_next.srq_mask[las_pkg::COMM_ERR_BIT] =
                ~i_link_select_pin_a;
        end

        // Hardware disable edge drops the software enable
        st_next.dis_prev = hw_disabled_flag;
        if (i_sw_output_enable_set) begin
            st_next.sw_enable = 1'b1;
        end
        if (hw_disabled_flag && !st_reg.dis_prev) begin
            st_next.sw_enable = 1'b0;
        end

        // Output lines from next-state latches and masks, registered with them
        st_next.srq_n = ~(|({hw_disabled_flag, st_next.warn_latch[3:0],
                             st_next.fatal_latch} &
                            st_next.srq_mask[12:0]));
        // Severe mask shares the status layout: bit 12 is the disable pin,
        // so the warning event bits 7:4 never leak into mask bits 15:12
        st_next.severe_n = ~(|({hw_disabled_flag,
                                st_next.warn_latch[3:0],
                                st_next.fatal_latch} &
                               st_next.severe_mask[12:0]));

        // Read data
        case (i_req.addr)
            las_pkg::FATAL_STATUS_ADDR:   st_next.rdata = fatal_status;
            las_pkg::WARNING_STATUS_ADDR: st_next.rdata = warning_status;
            las_pkg::PWR_FATAL_TH_ADDR:   st_next.rdata = st_reg.pwr_fatal_th;
            las_pkg::PWR_WARN_TH_ADDR:    st_next.rdata = st_reg.pwr_warn_th;
            las_pkg::FRQ_FATAL_TH_ADDR:   st_next.rdata = st_reg.frq_fatal_th;
            las_pkg::FRQ_WARN_TH_ADDR:    st_next.rdata = st_reg.frq_warn_th;
            las_pkg::THM_FATAL_TH_ADDR:   st_next.rdata = st_reg.thm_fatal_th;
            las_pkg::THM_WARN_TH_ADDR:    st_next.rdata = st_reg.thm_warn_th;
            las_pkg::SRQ_MASK_ADDR:       st_next.rdata = st_reg.srq_mask;
            las_pkg::SEVERE_MASK_ADDR:    st_next.rdata = st_reg.severe_mask;
            default:                      st_next.rdata = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // State register; restart and link reset flags set by reset itself
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
            st_reg.fatal_latch <= las_pkg::LATCH_RST;
            st_reg.warn_latch <= las_pkg::LATCH_RST;
            st_reg.pwr_fatal_th <= las_pkg::TH_RST_DEFAULT;
            st_reg.pwr_warn_th <= las_pkg::TH_RST_DEFAULT;
            st_reg.frq_fatal_th <= las_pkg::TH_RST_DEFAULT;
            st_reg.frq_warn_th <= las_pkg::TH_RST_DEFAULT;
            st_reg.thm_fatal_th <= las_pkg::TH_RST_DEFAULT;
            st_reg.thm_warn_th <= las_pkg::TH_RST_DEFAULT;
            st_reg.srq_mask <= las_pkg::SRQ_MASK_RST_BASE;
            st_reg.severe_mask <= las_pkg::SEVERE_MASK_RST;
            st_reg.srq_n <= 1'b1;
            st_reg.severe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata = st_reg.rdata;
    assign o_service_request_line_n = st_reg.srq_n;
    assign o_severe_fault_line_n = st_reg.severe_n;
    assign o_module_reset_req = st_reg.module_rst;
    assign o_soft_reset_req = st_reg.soft_rst;
    assign o_clear_input_buffers = st_reg.clr_buf;
    assign o_sw_output_enable = st_reg.sw_enable;
    assign o_link_sel = st_reg.link_sel;

endmodule

`default_nettype wire

// ### testbench/las_alarm_asserts.sv
// Checker: port timing relations of the alarm block
`timescale 1ns/1ns
`default_nettype none
module las_alarm_asserts #(
    parameter logic [15:0] TH_MAX = 16'h7FFF
) (
    input wire logic              i_core_clk,
    input wire logic              i_rstn,
    input wire las_pkg::las_req_s i_req,
    input wire logic              i_req_valid,
    input wire logic              i_link_reset,
    input wire logic              i_hw_output_disable_pin_n,
    input wire logic [15:0]       o_rdata,
    input wire logic              o_service_request_line_n,
    input wire logic              o_severe_fault_line_n,
    input wire logic              o_module_reset_req,
    input wire logic              o_soft_reset_req,
    input wire logic              o_clear_input_buffers,
    input wire logic              o_sw_output_enable
);
    // ------------------------------------------------------------
    // Properties, all on the core clock
    // ------------------------------------------------------------
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    // Writes to the reset register, kept as signals for the past values
    wire logic rst_wr  = i_req_valid && i_req.wr && i_req.addr == 8'h32;
    wire logic hard_wr = rst_wr && i_req.wdata[0];
    wire logic soft_wr = rst_wr && i_req.wdata[1];
    a_hard_reset_req: assert property (
        o_module_reset_req == $past(hard_wr))
        else $error("module reset pulse does not match the write");
    a_soft_reset_req: assert property (
        o_soft_reset_req == $past(soft_wr))
        else $error("soft reset pulse does not match the write");
    a_link_clear_pulse: assert property (
        i_link_reset |=> o_clear_input_buffers)
        else $error("link reset did not clear the input buffers");
    // Read data may come from the line before or after its update
    a_srq_bit_mirror: assert property (
        $past(i_req.addr) inside {8'h20, 8'h21} |->
        o_rdata[15] != $past(o_service_request_line_n) ||
        o_rdata[15] != o_service_request_line_n)
        else $error("status bit 15 disagrees with the service line");
    a_sev_bit_mirror: assert property (
        $past(i_req.addr) inside {8'h20, 8'h21} |->
        o_rdata[13] != $past(o_severe_fault_line_n) ||
        o_rdata[13] != o_severe_fault_line_n)
        else $error("status bit 13 disagrees with the severe line");
    a_status_bit14: assert property (
        $past(i_req.addr) inside {8'h20, 8'h21} |-> !o_rdata[14])
        else $error("status bit 14 read as one");
    a_thresh_clamp: assert property (
        $past(i_req.addr) inside {[8'h22:8'h27]} |-> o_rdata <= TH_MAX)
        else $error("threshold read above the allowed maximum");
    a_unmapped_zero: assert property (
        !($past(i_req.addr) inside {[8'h20:8'h29], 8'h32}) |->
        o_rdata == 16'h0000)
        else $error("unmapped address read as nonzero");
    a_sw_enable_drop: assert property (
        $fell(i_hw_output_disable_pin_n) |-> ##[1:2] !o_sw_output_enable)
        else $error("output enable survived the hardware disable");
    c_srq_low: cover property (!o_service_request_line_n);
    c_sev_low: cover property (!o_severe_fault_line_n);
    c_hard_reset: cover property (o_module_reset_req);
endmodule
bind las_alarm las_alarm_asserts #(.TH_MAX(TH_MAX)) chk_u (
    .i_core_clk, .i_rstn, .i_req, .i_req_valid, .i_link_reset,
    .i_hw_output_disable_pin_n, .o_rdata, .o_service_request_line_n,
    .o_severe_fault_line_n, .o_module_reset_req, .o_soft_reset_req,
    .o_clear_input_buffers, .o_sw_output_enable);
`default_nettype wire

// ### testbench/las_host_model.sv
// Host model: register requests toward the alarm block
`timescale 1ns/1ns
`default_nettype none
module las_host_model (
    input  wire logic              i_core_clk,
    input  wire logic [15:0]       i_rdata,
    output var las_pkg::las_req_s  o_req,
    output logic                   o_req_valid
);
    // Quiet bus from time zero
    initial begin
        o_req = '0;
        o_req_valid = 1'h0;
    end
    // Write held through the taking edge, then an idle cycle so the
    // strobe never rises in the same step that lowered it
    task automatic wr(input logic [7:0] a, input logic [15:0] dat);
        o_req = '{1'h1, a, dat};
        o_req_valid = 1'h1;
        @(negedge i_core_clk);
        o_req_valid = 1'h0;
        o_req.wr = 1'h0;
        o_req.wdata = ~dat; // Stale data never left standing
        @(negedge i_core_clk);
    endtask
    // Read needs only the address; data settles by the next fall
    task automatic rd(input logic [7:0] a, output logic [15:0] dat);
        o_req.addr = a;
        @(negedge i_core_clk);
        dat = i_rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/las_alarm_tb_top.sv
// Testbench: alarm block driven by the host model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module las_alarm_tb_top;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic vld, busy = 1'h0, dis_n = 1'h1, pa = 1'h0, cfg = 1'h0, ena = 1'h0;
    logic pb = 1'h0;
    logic srq_n, sev_n, mrst, srst, clr, swe;
    logic [1:0] lsel;
    logic [4:0] ev = 5'h00;
    logic [7:0] lf, lw;
    logic [15:0] rdata, d, v, mk, sm;
    logic [15:0] th [6];
    logic [31:0] seed = 32'h00011305;
    int n_errors = 0;
    int checked = 0;
    las_pkg::las_req_s req;
    las_pkg::las_mon_s mon = '0;
    // 10 MHz core clock
    always #50 core_clk = ~core_clk;
    las_host_model host_u (.i_core_clk(core_clk), .i_rdata(rdata),
                           .o_req(req), .o_req_valid(vld));
    las_alarm dut_u (
        .i_core_clk(core_clk), .i_rstn(rstn), .i_req(req), .i_req_valid(vld),
        .i_mon(mon), .i_exec_error_flag(ev[0]), .i_pending_exec_error(ev[1]),
        .i_comm_error(ev[2]), .i_fw_restart(ev[3]), .i_link_reset(ev[4]),
        .i_packet_busy(busy), .i_hw_output_disable_pin_n(dis_n),
        .i_link_select_pin_a(pa), .i_link_select_pin_b(pb),
        .i_immediate_error_latch_cfg(cfg), .i_sw_output_enable_set(ena),
        .o_rdata(rdata), .o_service_request_line_n(srq_n),
        .o_severe_fault_line_n(sev_n), .o_module_reset_req(mrst),
        .o_soft_reset_req(srst), .o_clear_input_buffers(clr),
        .o_sw_output_enable(swe), .o_link_sel(lsel));
    // ------------------------------------------------------------
    // Expectation model and helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h80200003 : 32'h00000000);
        return seed[15:0];
    endfunction
    // Current bits 11:8; strict compare so equality does not trip
    function automatic logic [3:0] cur(input int w);
        return {w ? mon.caution_vendor : mon.severe_vendor_caution[3],
                mon.frq_dev > th[2 + w], mon.thm_dev > th[4 + w],
                mon.pwr_dev > th[w]};
    endfunction
    function automatic logic [15:0] stat(input int w);
        logic [15:0] s;
        s = {3'h0, ~dis_n, lw[3:0], lf};
        return {|(mk & s), 1'h0, |(sm & s), ~dis_n, cur(w), w ? lw : lf};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Settle, fold current conditions into the latches, read both
    task automatic chk_st();
        repeat (2) @(negedge core_clk);
        lf[3:0] = lf[3:0] | cur(0);
        lw[3:0] = lw[3:0] | cur(1);
        host_u.rd(8'h20, d);
        `CHK(d, stat(0));
        host_u.rd(8'h21, d);
        `CHK(d, stat(1));
    endtask
    task automatic init();
        rstn = 1'h0;
        lf = 8'h30;
        lw = 8'h30;
        mk = pa ? 16'h1FBF : 16'h1FFF;
        sm = 16'h000F;
        foreach (th[i]) th[i] = 16'h0100;
        repeat (3) @(negedge core_clk);
        rstn = 1'h1;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        init();
        for (int i = 0; i < 10; i++) begin
            host_u.rd(8'h20 + 8'(i), d);
            `CHK(d, i < 2 ? stat(i) : i < 8 ? th[i - 2] : i > 8 ? sm : mk);
        end
        host_u.wr(8'h20, 16'hFF00);
        chk_st();
        host_u.wr(8'h20, 16'h00FF);
        host_u.wr(8'h21, 16'h00FF);
        lf = 8'h00;
        lw = 8'h00;
        chk_st();
        // Over-range and top values, then random with warning under fatal
        for (int i = 0; i < 18; i++) begin
            v = i < 12 ? 16'h7FFF + 16'(i < 6) : rnd() & 16'h03FF;
            if (i > 11 && i % 2 == 1) v = th[i % 6 - 1] >> 1;
            th[i % 6] = v > 16'h7FFF ? 16'h7FFF : v;
            host_u.wr(8'h22 + 8'(i % 6), v);
            host_u.rd(8'h22 + 8'(i % 6), d);
            `CHK(d, th[i % 6]);
        end
        // Deviations equal to, one above, and around the thresholds
        for (int i = 0; i < 24; i++) begin
            mon.pwr_dev = i < 2 ? th[0] + 16'(i) : rnd() & 16'h03FF;
            mon.frq_dev = i < 2 ? th[2] + 16'(i) : rnd() & 16'h03FF;
            mon.thm_dev = i < 2 ? th[4] + 16'(i) : rnd() & 16'h03FF;
            mon.caution_vendor = i[2];
            mon.severe_vendor_caution = {i[3], 3'h0};
            chk_st();
            if (i % 6 == 5) begin
                host_u.wr(8'h20, 16'h000F);
                host_u.wr(8'h21, 16'h000F);
                // Faults still present relatch at the clear edge
                lf[3:0] = cur(0);
                lw[3:0] = cur(1);
            end
        end
        // Every event pulse, immediate-error latching off then on
        for (int i = 0; i < 10; i++) begin
            cfg = i[0];
            ev[i / 2] = 1'h1;
            @(negedge core_clk);
            ev = 5'h00;
            `CHK(clr, i > 7);
            v = i == 0 || i == 4 ? 16'h0000 : 16'h0080 >> (i < 4 ? 0 : i / 2 - 1);
            lf = lf | v[7:0];
            lw = lw | v[7:0];
            chk_st();
            host_u.wr(8'h20, 16'h00F0);
            host_u.wr(8'h21, 16'h00F0);
            lf[7:4] = 4'h0;
            lw[7:4] = 4'h0;
        end
        // Restart in the very cycle that the clear is taken
        ev[3] = 1'h1;
        fork
            host_u.wr(8'h20, 16'h00FF);
            begin
                @(negedge core_clk);
                ev[3] = 1'h0;
            end
        join
        lf = 8'h20;
        lw = lw | 8'h20;
        chk_st();
        for (int i = 0; i < 5; i++) begin
            mk = i == 4 ? 16'h0000 : rnd() & 16'h1FFF;
            sm = i == 4 ? 16'h0000 : ~mk & 16'h1FFF;
            host_u.wr(8'h28, mk);
            host_u.wr(8'h29, sm);
            chk_st();
        end
        `CHK({srq_n, sev_n}, 2'h3);
        host_u.wr(8'h28, 16'h1000);
        mk = 16'h1000;
        ena = 1'h1;
        @(negedge core_clk);
        ena = 1'h0;
        @(negedge core_clk);
        `CHK(swe, 1'h1);
        dis_n = 1'h0;
        chk_st();
        `CHK(swe, 1'h0);
        dis_n = 1'h1;
        chk_st();
        `CHK(swe, 1'h0);
        // Packet left incomplete past the link timeout
        busy = 1'h1;
        repeat (int'(las_pkg::LINK_TIMEOUT_CYC) + 4) @(negedge core_clk);
        busy = 1'h0;
        lf[4] = 1'h1;
        lw[4] = 1'h1;
        chk_st();
        host_u.wr(8'h2A, rnd());
        host_u.rd(8'h2A, d);
        `CHK(d, 16'h0000);
        fork
            host_u.wr(8'h32, 16'h0003);
            begin
                @(negedge core_clk);
                `CHK({mrst, srst}, 2'h3);
            end
        join
        // Second reset in mid-run with the RS232 strap
        pa = 1'h1;
        init();
        host_u.rd(8'h28, d);
        `CHK(d, 16'h1FBF);
        `CHK(lsel, 2'h1);
        chk_st();
        // Third reset with the I2C strap
        pa = 1'h0;
        pb = 1'h1;
        init();
        host_u.rd(8'h28, d);
        `CHK(d, 16'h1FFF);
        `CHK(lsel, 2'h2);
        final_report();
    end
    // Watchdog: the timeout wait plus a wide margin for the rest
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
